/* core/asc_pkg.sv */
// package: constants for the async sram host controller
package asc_pkg;

    localparam int ADDR_W      = 19;
    localparam int DATA_W      = 24;
    localparam int LANE_W      = 8;
    localparam int LANES       = 3;

    // clock and pin timing, ns
    localparam int CLK_NS      = 25;
    localparam int T_RC_NS     = 8;   // read cycle, least
    localparam int T_PWE_NS    = 6;   // write pulse, least
    localparam int T_SD_NS     = 5;   // data setup to write end, least
    localparam int T_HZWE_NS   = 5;   // strobe low to memory high z, most
    localparam int T_HZOE_NS   = 5;   // gate high to memory high z, most

    // least times round up to whole cycles, never below one
    localparam int RD_CYC      = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC      = ((T_PWE_NS > (T_HZWE_NS + T_SD_NS) ? T_PWE_NS : (T_HZWE_NS + T_SD_NS))
                                  + CLK_NS - 1) / CLK_NS;
    localparam int TURN_CYC    = (T_HZOE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W       = 4;

    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] RD_CNT   = CNT_W'(RD_CYC);
    localparam logic [CNT_W-1:0] WR_CNT   = CNT_W'(WR_CYC);
    localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);

    localparam logic [LANES-1:0] LANES_OFF = 3'h7;

    typedef enum logic [2:0] {
        ASC_IDLE,
        ASC_RD_SEL,
        ASC_RD_HOLD,
        ASC_TURN,
        ASC_WR_SEL,
        ASC_WR_PULSE,
        ASC_WR_END
    } asc_state_t;

endpackage

/* core/asc_sync2.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps

module asc_sync2
#(
    parameter int W = 1
)
(
    // clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_arst_n,
    // data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        meta_nxt = i_d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_r <= '0;
            o_q    <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            o_q    <= q_nxt;
        end
    end

endmodule // asc_sync2

/* core/asc_host.sv */
// host controller driving a 24-bit async sram with three byte-lane selects
`timescale 1ns/10ps

// Function
// - every read keeps the write strobe high for the whole access.
// - the address is driven and stable before the combined select goes low.
// - every write holds the gate high, so the memory never drives and the host drives data on the same edge the strobe falls.
// - with all selects low and the strobe low the memory stores the whole 24-bit word and ignores the gate.
// - a write lasts only while selects and strobe overlap, and data is held through the edge that ends it.
module asc_host
    import asc_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_arst_n,
    // user request
    input  wire logic              i_req,
    input  wire logic              i_write,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [LANES-1:0]  i_lane_en,
    output logic                   o_ready,
    output logic                   o_rvalid,
    output logic [DATA_W-1:0]      o_rdata,
    // memory pins
    output logic [ADDR_W-1:0]      o_sram_addr,
    output logic                   o_low_byte_select_n,
    output logic                   o_mid_byte_select_n,
    output logic                   o_high_byte_select_n,
    output logic                   o_sram_oe_n,
    output logic                   o_sram_we_n,
    output logic [DATA_W-1:0]      o_sram_dq,
    output logic [DATA_W-1:0]      o_sram_dq_oe_n,
    input  wire logic [DATA_W-1:0] i_sram_dq
);

    ////////////////////////////////////////////////////////////////////////////
    // pin input synchroniser
    logic [DATA_W-1:0] dq_sync;

    asc_sync2 #(.W(DATA_W)) u_dq_sync
    (
        .i_clk_sys (i_clk_sys),
        .i_arst_n  (i_arst_n),
        .i_d       (i_sram_dq),
        .o_q       (dq_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state
    asc_state_t        state_r,   state_nxt;
    logic [CNT_W-1:0]  cnt_r,     cnt_nxt;
    logic [ADDR_W-1:0] addr_r,    addr_nxt;
    logic [LANES-1:0]  sel_n_r,   sel_n_nxt;
    logic              oe_n_r,    oe_n_nxt;
    logic              we_n_r,    we_n_nxt;
    logic [DATA_W-1:0] dq_r,      dq_nxt;
    logic              dq_drv_r,  dq_drv_nxt;
    logic              ready_r,   ready_nxt;
    logic              rvalid_r,  rvalid_nxt;
    logic [DATA_W-1:0] rdata_r,   rdata_nxt;
    logic [LANES-1:0]  lane_en_r, lane_en_nxt;

    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        addr_nxt    = addr_r;
        sel_n_nxt   = sel_n_r;
        oe_n_nxt    = oe_n_r;
        we_n_nxt    = we_n_r;
        dq_nxt      = dq_r;
        dq_drv_nxt  = dq_drv_r;
        ready_nxt   = ready_r;
        rvalid_nxt  = 1'b0;
        rdata_nxt   = rdata_r;
        lane_en_nxt = lane_en_r;
        case (state_r)
            ASC_IDLE:
            begin
                // standby: all selects high, nothing driven
                sel_n_nxt  = LANES_OFF;
                we_n_nxt   = 1'b1;
                oe_n_nxt   = 1'b1;
                dq_drv_nxt = 1'b0;
                ready_nxt  = 1'b1;
                if (i_req && ready_r)
                begin
                    ready_nxt   = 1'b0;
                    // address goes out one cycle ahead of any select
                    addr_nxt    = i_addr;
                    lane_en_nxt = i_lane_en;
                    dq_nxt      = i_wdata;
                    state_nxt   = i_write ? ASC_WR_SEL : ASC_RD_SEL;
                end
            end
            ASC_RD_SEL:
            begin
                // strobe stays high throughout a read
                we_n_nxt  = 1'b1;
                oe_n_nxt  = 1'b0;
                // only enabled lanes are selected; others stay high z
                sel_n_nxt = ~lane_en_r;
                // sample after the pins settle plus the synchroniser lag
                cnt_nxt   = RD_CNT + CNT_ONE + CNT_ONE;
                state_nxt = ASC_RD_HOLD;
            end
            ASC_RD_HOLD:
            begin
                if (cnt_r == CNT_ZERO)
                begin
                    for (int l = 0; l < LANES; l++)
                    begin
                        // unselected lanes read as zero rather than floating bus noise
                        rdata_nxt[l*LANE_W +: LANE_W] = lane_en_r[l] ? dq_sync[l*LANE_W +: LANE_W] : '0;
                    end
                    rvalid_nxt = 1'b1;
                    sel_n_nxt  = LANES_OFF;
                    // gate high releases the memory's drivers
                    oe_n_nxt   = 1'b1;
                    cnt_nxt    = TURN_CNT;
                    state_nxt  = ASC_TURN;
                end
                else
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            ASC_TURN:
            begin
                // bus turnaround: memory is high z once gate and selects are high
                if (cnt_r == CNT_ZERO)
                begin
                    state_nxt = ASC_IDLE;
                end
                else
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            ASC_WR_SEL:
            begin
                // gate held high so the memory never drives while we do
                oe_n_nxt   = 1'b1;
                sel_n_nxt  = ~lane_en_r;
                dq_drv_nxt = 1'b1;
                we_n_nxt   = 1'b0;
                cnt_nxt    = WR_CNT;
                state_nxt  = ASC_WR_PULSE;
            end
            ASC_WR_PULSE:
            begin
                // overlap of selects and low strobe is the write window
                if (cnt_r == CNT_ONE)
                begin
                    // strobe ends the write; selects and data stay one more cycle
                    we_n_nxt  = 1'b1;
                    state_nxt = ASC_WR_END;
                end
                else
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                end
            end
            ASC_WR_END:
            begin
                // data released only after the strobe edge, and selects drop in the same cycle
                dq_drv_nxt = 1'b0;
                sel_n_nxt  = LANES_OFF;
                cnt_nxt    = TURN_CNT;
                state_nxt  = ASC_TURN;
            end
            default:
            begin
                state_nxt = ASC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r   <= ASC_IDLE;
            cnt_r     <= CNT_ZERO;
            addr_r    <= '0;
            sel_n_r   <= LANES_OFF;
            oe_n_r    <= 1'b1;
            we_n_r    <= 1'b1;
            dq_r      <= '0;
            dq_drv_r  <= 1'b0;
            ready_r   <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            lane_en_r <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            addr_r    <= addr_nxt;
            sel_n_r   <= sel_n_nxt;
            oe_n_r    <= oe_n_nxt;
            we_n_r    <= we_n_nxt;
            dq_r      <= dq_nxt;
            dq_drv_r  <= dq_drv_nxt;
            ready_r   <= ready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            lane_en_r <= lane_en_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all flops
    assign o_ready              = ready_r;
    assign o_rvalid             = rvalid_r;
    assign o_rdata              = rdata_r;
    assign o_sram_addr          = addr_r;
    assign o_low_byte_select_n  = sel_n_r[0];
    assign o_mid_byte_select_n  = sel_n_r[1];
    assign o_high_byte_select_n = sel_n_r[2];
    assign o_sram_oe_n          = oe_n_r;
    assign o_sram_we_n          = we_n_r;
    assign o_sram_dq            = dq_r;
    assign o_sram_dq_oe_n       = {DATA_W{~dq_drv_r}};

endmodule // asc_host

/* verif/asc_host_props.sv */
// checker on the host controller pins
`timescale 1ns/10ps
module asc_host_props
    import asc_pkg::*;
(
    // watched ports
    input wire logic              i_clk_sys,
    input wire logic              i_arst_n,
    input wire logic              i_req,
    input wire logic              i_write,
    input wire logic              o_ready,
    input wire logic              o_rvalid,
    input wire logic [ADDR_W-1:0] o_sram_addr,
    input wire logic              o_low_byte_select_n,
    input wire logic              o_mid_byte_select_n,
    input wire logic              o_high_byte_select_n,
    input wire logic              o_sram_oe_n,
    input wire logic              o_sram_we_n,
    input wire logic [DATA_W-1:0] o_sram_dq,
    input wire logic [DATA_W-1:0] o_sram_dq_oe_n
);
    wire logic [LANES-1:0] sel_n = {o_high_byte_select_n, o_mid_byte_select_n, o_low_byte_select_n};

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    a_rd_strobe_high: assert property (!o_sram_oe_n |-> o_sram_we_n)
        else $error("strobe low while gate low");
    a_addr_before_sel: assert property ($past(sel_n) == LANES_OFF && sel_n != LANES_OFF |-> $stable(o_sram_addr))
        else $error("address moved as selects fell");
    a_write_gate_off: assert property (!o_sram_we_n |-> o_sram_oe_n && sel_n != LANES_OFF)
        else $error("write without select or with gate low");
    a_no_clash: assert property (!o_sram_oe_n |-> &o_sram_dq_oe_n)
        else $error("host drives data while gate low");
    a_write_hold: assert property ($rose(o_sram_we_n) |-> !o_sram_dq_oe_n[0] && $stable(o_sram_dq) && $stable(sel_n))
        else $error("data or selects not held at write end");
    a_idle_standby: assert property (o_ready |-> sel_n == LANES_OFF && &o_sram_dq_oe_n)
        else $error("idle host not in standby");
    a_read_answer: assert property (o_ready && i_req && !i_write |-> ##6 o_rvalid)
        else $error("read data late or missing");
    a_write_pulse: assert property (o_ready && i_req && i_write |-> ##2 !o_sram_we_n ##1 o_sram_we_n)
        else $error("write strobe pulse wrong");

    c_write: cover property (o_ready && i_req && i_write);
    c_read: cover property (o_ready && i_req && !i_write);
    c_part: cover property (!o_sram_oe_n && sel_n != LANES_OFF && sel_n != 3'h0);
    c_part_write: cover property (!o_sram_we_n && sel_n != LANES_OFF && sel_n != 3'h0);
endmodule // asc_host_props

bind asc_host asc_host_props asc_host_props_i (.*);

/* verif/asc_sram_model.sv */
// behavioural async sram on the far side of the host
`timescale 1ns/10ps
module asc_sram_model
    import asc_pkg::*;
(
    // memory pins
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [LANES-1:0]  i_sel_n,
    input  wire logic              i_oe_n,
    input  wire logic              i_we_n,
    input  wire logic [DATA_W-1:0] i_dq,
    output logic      [DATA_W-1:0] o_dq
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] held = 24'h0;
    logic [LANES-1:0]  drive;

    // lane written only while its select and strobe overlap; gate ignored
    always @*
        for (int l = 0; l < LANES; l++)
            if (!i_sel_n[l] && !i_we_n)
                mem[i_addr][l*LANE_W +: LANE_W] = i_dq[l*LANE_W +: LANE_W];

    // lane drives only with strobe high and gate low
    // pin-level sensitivity keeps the process off the event list of the whole array
    always @(i_addr or i_sel_n or i_oe_n or i_we_n)
        for (int l = 0; l < LANES; l++)
        begin
            drive[l] = !i_sel_n[l] && i_we_n && !i_oe_n;
            if (drive[l])
                held[l*LANE_W +: LANE_W] = mem[i_addr][l*LANE_W +: LANE_W];
        end

    // a released lane shows the inverse of its last byte so stale data never looks valid
    always @*
        for (int l = 0; l < LANES; l++)
            o_dq[l*LANE_W +: LANE_W] = drive[l] ? held[l*LANE_W +: LANE_W] : ~held[l*LANE_W +: LANE_W];
endmodule // asc_sram_model

/* verif/asc_host_tb.sv */
// self-checking bench: host controller against the sram model
`timescale 1ns/10ps
module asc_host_tb
    import asc_pkg::*;
;
    typedef struct packed {logic w; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [LANES-1:0] l;
                           logic [DATA_W-1:0] e;} asc_row_t;
    logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_req = 1'b0, i_write = 1'b0;
    logic [ADDR_W-1:0] i_addr = 19'h0;
    logic [DATA_W-1:0] i_wdata = 24'h0;
    logic [LANES-1:0]  i_lane_en = 3'h0;
    logic o_ready, o_rvalid, o_low_byte_select_n, o_mid_byte_select_n, o_high_byte_select_n, o_sram_oe_n, o_sram_we_n;
    logic [DATA_W-1:0] o_rdata, o_sram_dq, o_sram_dq_oe_n, i_sram_dq, mdl_dq;
    logic [ADDR_W-1:0] o_sram_addr;
    int num_errors = 0;
    int checked = 0;
    localparam asc_row_t ROWS [12] = '{
        '{1'h1, 19'h00005, 24'hA1B2C3, 3'h7, 24'h0},
        '{1'h0, 19'h00005, 24'h0, 3'h7, 24'hA1B2C3},
        '{1'h0, 19'h00005, 24'h0, 3'h1, 24'h0000C3},
        '{1'h0, 19'h00005, 24'h0, 3'h2, 24'h00B200},
        '{1'h0, 19'h00005, 24'h0, 3'h4, 24'hA10000},
        '{1'h1, 19'h7FFFF, 24'h123456, 3'h7, 24'h0},
        '{1'h1, 19'h7FFFF, 24'hFFFFEE, 3'h1, 24'h0},
        '{1'h0, 19'h7FFFF, 24'h0, 3'h7, 24'h1234EE},
        '{1'h1, 19'h7FFFF, 24'h99AAFF, 3'h6, 24'h0},
        '{1'h0, 19'h7FFFF, 24'h0, 3'h7, 24'h99AAEE},
        '{1'h0, 19'h7FFFF, 24'h0, 3'h5, 24'h9900EE},
        '{1'h0, 19'h00005, 24'h0, 3'h3, 24'h00B2C3}};

    // the pin bus: host wins where it drives, else the memory side
    assign i_sram_dq = (o_sram_dq & ~o_sram_dq_oe_n) | (mdl_dq & o_sram_dq_oe_n);
    always #(CLK_NS / 2.0) i_clk_sys = ~i_clk_sys;

    asc_host asc_host_i (.*);
    asc_sram_model asc_sram_model_i (
        .i_addr  (o_sram_addr),
        .i_sel_n ({o_high_byte_select_n, o_mid_byte_select_n, o_low_byte_select_n}),
        .i_oe_n  (o_sram_oe_n),
        .i_we_n  (o_sram_we_n),
        .i_dq    (i_sram_dq),
        .o_dq    (mdl_dq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one request; waits for ready, and for the data pulse on a read
    task automatic run(input asc_row_t r, output logic [DATA_W-1:0] q);
        int n;
        for (n = 0; n < 40 && o_ready !== 1'b1; n++) @(negedge i_clk_sys);
        chk("ready", 24'h1, {23'h0, o_ready});
        {i_write, i_addr, i_wdata, i_lane_en} = {r.w, r.a, r.d, r.l};
        i_req = 1'b1;
        @(negedge i_clk_sys);
        i_req = 1'b0;
        for (n = 0; n < 20 && !r.w && o_rvalid !== 1'b1; n++) @(negedge i_clk_sys);
        if (!r.w) chk("rvalid", 24'h1, {23'h0, o_rvalid});
        q = o_rdata;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [DATA_W-1:0] q;
        repeat (4) @(negedge i_clk_sys);
        i_arst_n = 1'b1;
        foreach (ROWS[k])
        begin
            run(ROWS[k], q);
            if (!ROWS[k].w) chk("rdata", ROWS[k].e, q);
            $display("row %0d done", k);
        end
        // a request while busy is dropped silently
        run('{1'h1, 19'h00100, 24'h5A5A5A, 3'h7, 24'h0}, q);
        i_wdata = 24'h0;
        i_req = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        i_req = 1'b0;
        run('{1'h0, 19'h00100, 24'h0, 3'h7, 24'h0}, q);
        chk("busy refusal", 24'h5A5A5A, q);
        $display("refusal done");
        // reset in the middle of a read returns the pins to standby
        for (int n = 0; n < 40 && o_ready !== 1'b1; n++) @(negedge i_clk_sys);
        {i_write, i_addr, i_lane_en, i_req} = {1'b0, 19'h00005, 3'h7, 1'b1};
        @(negedge i_clk_sys);
        i_req = 1'b0;
        @(negedge i_clk_sys);
        i_arst_n = 1'b0;
        @(negedge i_clk_sys);
        chk("reset pins", 24'h3F, {16'h0, o_ready, o_rvalid, o_low_byte_select_n, o_mid_byte_select_n,
            o_high_byte_select_n, o_sram_oe_n, o_sram_we_n, &o_sram_dq_oe_n});
        chk("reset rdata", 24'h0, o_rdata);
        i_arst_n = 1'b1;
        run('{1'h0, 19'h00005, 24'h0, 3'h7, 24'h0}, q);
        chk("read after reset", 24'hA1B2C3, q);
        $display("reset test done");
        close_out();
    end

    initial
    begin
        #(CLK_NS * 3000);
        num_errors++;
        close_out();
    end
endmodule // asc_host_tb
